//--- shared/tef_pkg.sv
package tef_pkg;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] TEF_OFF_CTRL    = 8'h00;
	localparam logic [7:0] TEF_OFF_MODE    = 8'h04;
	localparam logic [7:0] TEF_OFF_CHDIR   = 8'h08;
	localparam logic [7:0] TEF_OFF_ENABLE  = 8'h0c;
	localparam logic [7:0] TEF_OFF_FLAGS   = 8'h10;
	localparam logic [7:0] TEF_OFF_EVGEN   = 8'h14;
	localparam logic [7:0] TEF_OFF_COUNT   = 8'h24;
	localparam logic [7:0] TEF_OFF_PSC     = 8'h28;
	localparam logic [7:0] TEF_OFF_RELOAD  = 8'h2c;
	localparam logic [7:0] TEF_OFF_REPEAT  = 8'h30;
	localparam logic [7:0] TEF_OFF_CCR1    = 8'h34;
	localparam logic [7:0] TEF_OFF_CFGPRE  = 8'h44;
	localparam logic [7:0] TEF_OFF_CFGACT  = 8'h48;
	localparam logic [1:0] TEF_CCR_STRIDE  = 2'h2;
	localparam logic [2:0] TEF_CH_COUNT    = 3'h4;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int TEF_CTRL_EN      = 0;
	localparam int TEF_CTRL_UPDATE_DISABLE    = 1;
	localparam int TEF_CTRL_URS     = 2;
	localparam int TEF_CTRL_DOWN    = 4;
	localparam int TEF_CTRL_CMS_LO  = 5;
	localparam int TEF_MODE_PRELOAD = 0;
	localparam int TEF_MODE_MOE     = 1;
	localparam int TEF_MODE_GATED   = 2;
	localparam int TEF_MODE_RESET   = 3;
	localparam int TEF_FL_UPD       = 0;
	localparam int TEF_FL_CC1       = 1;
	localparam int TEF_FL_COM       = 5;
	localparam int TEF_FL_TRG       = 6;
	localparam int TEF_FL_BRK       = 7;
	localparam int TEF_FL_OF1       = 9;
	localparam int TEF_EV_UG        = 0;
	localparam int TEF_EV_CH1_EVENT_GENERATE      = 1;
	localparam int TEF_EV_COMMUTATION_GENERATE      = 5;
	localparam int TEF_EV_TG        = 6;
	localparam int TEF_EV_BG        = 7;
	localparam int TEF_IE_DMA_LO    = 8;

	// ------------------------------------------------------------
	// masks and reset values
	// ------------------------------------------------------------
	localparam logic [15:0] TEF_FLAGS_MASK  = 16'h1eff;
	localparam logic [15:0] TEF_ENABLE_MASK = 16'h7fff;
	localparam logic [15:0] TEF_RST_16      = 16'h0000;
	localparam logic [15:0] TEF_RST_RELOAD  = 16'hffff;
	localparam logic [1:0]  TEF_HTRANS_NSEQ = 2'h2;

	// data phase sequencer
	typedef enum logic [1:0] {
		TEF_BUS_IDLE  = 2'b00,
		TEF_BUS_WRITE = 2'b01,
		TEF_BUS_RDWT  = 2'b10,
		TEF_BUS_RDOK  = 2'b11
	} tef_bus_t;

	typedef struct packed {
		tef_bus_t        bus;
		logic [7:0]      busAddr;
		logic [31:0]     rdata;
		logic [6:0]      ctrl;
		logic [3:0]      mode;
		logic [3:0]      chInput;
		logic [15:0]     enables;
		logic [15:0]     flags;
		logic [15:0]     count;
		logic            countDown;
		logic [15:0]     psc;
		logic [15:0]     pscCount;
		logic [15:0]     reload;
		logic [7:0]      repeatVal;
		logic [7:0]      repeatCount;
		logic [3:0][15:0] ccr;
		logic [15:0]     cfgPre;
		logic [15:0]     cfgAct;
	} tef_state_t;
endpackage

//--- core/tef_flags.sv
`timescale 1ns/1ps
// Overview of operation
// - capture while capture flag set sets overcapture
// - overcapture cleared only by software zero write
// - active brake input sets sticky brake flag
// - trigger flag on trigger; gated counts any edge
// - commutation update sets sticky commutation flag
// - output channel match sets flag, not centered
// - input capture sets flag; read or write clears
// - update event sets update flag, software clears
// - repetition rollover updates unless update disabled
// - software/trigger reinit updates only if both zero
// - brake generate clears output enable, sets flag
// - trigger generate sets trigger flag, self clears
// - commutation generate loads config when preload set
// - channel generate on output sets compare flag
// - channel generate on input captures counter
// - update generate reinitialises counter, self clears
// - update generate clears prescaler and counter
// - down counting reloads counter from reload value
// - interrupt and DMA requests gated by enables
module tef_flags
	import tef_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic [3:0]  captureEvent,
	input  wire logic        triggerActiveEdge,
	input  wire logic        triggerAnyEdge,
	input  wire logic        gateLevel,
	input  wire logic        brakeActive,
	input  wire logic        commutationEvent,
	output logic [15:0]      mainCounter,
	output logic             mainOutputEnable,
	output logic [15:0]      channelConfig,
	output logic [7:0]       irqRequest,
	output logic [6:0]       dmaRequest
);
	import tef_pkg::*;

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	// capture/compare register index for an offset, valid flag on top
	function automatic logic [2:0] ccrIndex(input logic [7:0] addr);
		logic [7:0] rel;
		rel = addr - TEF_OFF_CCR1;
		ccrIndex = 3'h0;
		if (addr >= TEF_OFF_CCR1 && rel[7:TEF_CCR_STRIDE] < 6'(TEF_CH_COUNT)
			&& rel[1:0] == 2'h0)
			ccrIndex = {1'b1, rel[3:2]};
	endfunction

	tef_state_t st;
	tef_state_t next_st;

	logic        addrTaken;
	logic        wrPhase;
	logic [15:0] wdata;
	logic [7:0]  evgen;
	logic        centered;
	logic        countRun;
	logic        pscTick;
	logic        wrapEvent;
	logic        repeatRoll;
	logic        reinitSw;
	logic        reinitTrg;
	logic        updateEvent;
	logic        triggerEvent;
	logic        comEvent;
	logic [15:0] countNext;
	logic        dirNext;
	logic [3:0]  chCapture;
	logic [3:0]  chMatch;
	logic [2:0]  rdIdx;

	// ------------------------------------------------------------
	// bus phase decode
	// ------------------------------------------------------------
	assign addrTaken = hsel && hready && htrans == TEF_HTRANS_NSEQ;
	assign wrPhase   = st.bus == TEF_BUS_WRITE;
	assign wdata     = hwdata[15:0];
	// generate bits never store; zero bits produce no strobe
	assign evgen     = (wrPhase && st.busAddr == TEF_OFF_EVGEN) ? wdata[7:0] : 8'h00;
	assign rdIdx     = ccrIndex(st.busAddr);

	// ------------------------------------------------------------
	// counter and prescaler
	// ------------------------------------------------------------
	assign centered = st.ctrl[TEF_CTRL_CMS_LO +: 2] != 2'h0;
	// gated mode only counts while the gate is high
	assign countRun = st.ctrl[TEF_CTRL_EN] && (!st.mode[TEF_MODE_GATED] || gateLevel);
	assign pscTick  = countRun && st.pscCount == st.psc;

	// next count and wrap detection for all three count modes
	always_comb
	begin
		countNext = st.count;
		dirNext   = st.countDown;
		wrapEvent = 1'b0;
		if (pscTick)
		begin
			if (!st.countDown)
			begin
				if (st.count >= st.reload)
				begin
					wrapEvent = 1'b1;
					countNext = centered ? st.count - 16'h0001 : TEF_RST_16;
					dirNext   = centered;
				end
				else
					countNext = st.count + 16'h0001;
			end
			else
			begin
				if (st.count == TEF_RST_16)
				begin
					wrapEvent = 1'b1;
					countNext = centered ? 16'h0001 : st.reload;
					dirNext   = !centered;
				end
				else
					countNext = st.count - 16'h0001;
			end
		end
	end

	// repetition counter rolls when it is exhausted at a wrap
	assign repeatRoll = wrapEvent && st.repeatCount == 8'h00;

	// ------------------------------------------------------------
	// event sources
	// ------------------------------------------------------------
	assign reinitSw     = evgen[TEF_EV_UG];
	assign reinitTrg    = st.mode[TEF_MODE_RESET] && triggerActiveEdge;
	assign triggerEvent = (st.mode[TEF_MODE_GATED] ? triggerAnyEdge : triggerActiveEdge)
		|| evgen[TEF_EV_TG];
	// the urs qualifier suppresses updates from software and slave reinit only
	assign updateEvent  = !st.ctrl[TEF_CTRL_UPDATE_DISABLE] && (repeatRoll
		|| (!st.ctrl[TEF_CTRL_URS] && (reinitSw || reinitTrg)));
	assign comEvent     = st.mode[TEF_MODE_PRELOAD]
		&& (evgen[TEF_EV_COMMUTATION_GENERATE] || commutationEvent);

	// per-channel capture and compare strobes
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_ch
			assign chCapture[gi] = st.chInput[gi]
				&& (captureEvent[gi] || evgen[TEF_EV_CH1_EVENT_GENERATE + gi]);
			assign chMatch[gi]   = !st.chInput[gi] && ((pscTick && !centered
				&& countNext == st.ccr[gi]) || evgen[TEF_EV_CH1_EVENT_GENERATE + gi]);
		end
	endgenerate

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_st = st;

		// bus sequencer: reads wait one cycle so that a preceding write has landed
		case (st.bus)
			TEF_BUS_RDWT:
			begin
				next_st.bus   = TEF_BUS_RDOK;
				next_st.rdata = 32'h0000_0000;
				case (st.busAddr)
					TEF_OFF_CTRL:   next_st.rdata[6:0]  = st.ctrl;
					TEF_OFF_MODE:   next_st.rdata[3:0]  = st.mode;
					TEF_OFF_CHDIR:  next_st.rdata[3:0]  = st.chInput;
					TEF_OFF_ENABLE: next_st.rdata[15:0] = st.enables;
					TEF_OFF_FLAGS:  next_st.rdata[15:0] = st.flags;
					TEF_OFF_COUNT:  next_st.rdata[15:0] = st.count;
					TEF_OFF_PSC:    next_st.rdata[15:0] = st.psc;
					TEF_OFF_RELOAD: next_st.rdata[15:0] = st.reload;
					TEF_OFF_REPEAT: next_st.rdata[7:0]  = st.repeatVal;
					TEF_OFF_CFGPRE: next_st.rdata[15:0] = st.cfgPre;
					TEF_OFF_CFGACT: next_st.rdata[15:0] = st.cfgAct;
					default:
					begin
						if (rdIdx[2])
							next_st.rdata[15:0] = st.ccr[rdIdx[1:0]];
					end
				endcase
			end
			default:
				next_st.bus = TEF_BUS_IDLE;
		endcase
		if (addrTaken)
		begin
			next_st.bus     = hwrite ? TEF_BUS_WRITE : TEF_BUS_RDWT;
			next_st.busAddr = haddr[7:0];
		end

		// plain register writes
		if (wrPhase)
		begin
			case (st.busAddr)
				TEF_OFF_CTRL:   next_st.ctrl    = wdata[6:0];
				TEF_OFF_MODE:   next_st.mode    = wdata[3:0];
				TEF_OFF_CHDIR:  next_st.chInput = wdata[3:0];
				TEF_OFF_ENABLE: next_st.enables = wdata & TEF_ENABLE_MASK;
				TEF_OFF_PSC:    next_st.psc     = wdata;
				TEF_OFF_RELOAD: next_st.reload  = wdata;
				TEF_OFF_REPEAT: next_st.repeatVal = wdata[7:0];
				TEF_OFF_CFGPRE: next_st.cfgPre  = wdata;
				// flags: zero clears, one keeps; sets are merged below so they win
				TEF_OFF_FLAGS:  next_st.flags   = st.flags & wdata;
				default:
				begin
					if (rdIdx[2] && !st.chInput[rdIdx[1:0]])
						next_st.ccr[rdIdx[1:0]] = wdata;
				end
			endcase
		end

		// reading a capture register drops that channel's capture flag
		if (st.bus == TEF_BUS_RDWT && rdIdx[2] && st.chInput[rdIdx[1:0]])
			next_st.flags[TEF_FL_CC1 + 32'(rdIdx[1:0])] = 1'b0;

		// counter, prescaler and repetition counter
		next_st.count     = countNext;
		next_st.countDown = centered ? dirNext : st.ctrl[TEF_CTRL_DOWN];
		if (countRun)
			next_st.pscCount = pscTick ? TEF_RST_16 : st.pscCount + 16'h0001;
		if (wrapEvent)
			next_st.repeatCount = repeatRoll ? st.repeatVal : st.repeatCount - 8'h01;
		if (wrPhase && st.busAddr == TEF_OFF_COUNT)
			next_st.count = wdata;
		// reinit keeps the prescaler factor, only its count restarts
		if (reinitSw || reinitTrg)
		begin
			next_st.pscCount    = TEF_RST_16;
			next_st.repeatCount = st.repeatVal;
			if (st.ctrl[TEF_CTRL_DOWN] && !centered)
				next_st.count = st.reload;
			else
				next_st.count = TEF_RST_16;
		end

		// captures: overcapture is judged on the flag before this cycle's clear
		for (int i = 0; i < 4; i++)
		begin
			if (chCapture[i])
			begin
				next_st.ccr[i] = st.count;
				next_st.flags[TEF_FL_CC1 + i] = 1'b1;
				if (st.flags[TEF_FL_CC1 + i])
					next_st.flags[TEF_FL_OF1 + i] = 1'b1;
			end
			if (chMatch[i])
				next_st.flags[TEF_FL_CC1 + i] = 1'b1;
		end

		// commutation loads the active channel configuration
		if (comEvent)
		begin
			next_st.cfgAct = st.cfgPre;
			next_st.flags[TEF_FL_COM] = 1'b1;
		end

		// brake: pin level or software strobe, output enable drops
		if (wrPhase && st.busAddr == TEF_OFF_MODE)
			next_st.mode[TEF_MODE_MOE] = wdata[TEF_MODE_MOE];
		if (brakeActive || evgen[TEF_EV_BG])
		begin
			next_st.mode[TEF_MODE_MOE] = 1'b0;
			next_st.flags[TEF_FL_BRK]  = 1'b1;
		end

		if (triggerEvent)
			next_st.flags[TEF_FL_TRG] = 1'b1;
		if (updateEvent)
			next_st.flags[TEF_FL_UPD] = 1'b1;

		next_st.flags = next_st.flags & TEF_FLAGS_MASK;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	// one synchronous reset for the whole state record
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			st             <= '0;
			st.bus         <= TEF_BUS_IDLE;
			st.reload      <= TEF_RST_RELOAD;
		end
		else
			st <= next_st;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// only the first read data cycle stalls; writes never wait
	assign hreadyout        = st.bus != TEF_BUS_RDWT;
	assign hresp            = 1'b0;
	assign hrdata           = st.rdata;
	assign mainCounter      = st.count;
	assign mainOutputEnable = st.mode[TEF_MODE_MOE];
	assign channelConfig    = st.cfgAct;
	// request levels follow the flags, so they drop when software clears
	assign irqRequest       = st.flags[7:0] & st.enables[7:0];
	assign dmaRequest       = st.flags[6:0] & st.enables[TEF_IE_DMA_LO +: 7];
endmodule

//--- verification/tef_flags_assertions.sv
`timescale 1ns/1ps
module tef_flags_checker
(
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        brakeActive,
	input wire logic        mainOutputEnable,
	input wire logic [7:0]  irqRequest,
	input wire logic [6:0]  dmaRequest
);
	import tef_pkg::*;
	logic wrPhase;
	wire  taken = hsel && hready && (htrans == TEF_HTRANS_NSEQ);
	// ------------------------------------------------------------
	// write data phase tracker
	// ------------------------------------------------------------
	// sticky flags may only drop while a write lands, so mark those cycles
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			wrPhase <= 1'b0;
		else if (hready)
			wrPhase <= taken && hwrite;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence readWait;
		!hreadyout ##1 hreadyout;
	endsequence
	sequence quietOut;
		hreadyout && !mainOutputEnable && irqRequest == 8'h00 && dmaRequest == 7'h00;
	endsequence
	// ------------------------------------------------------------
	// bus answer and output rules
	// ------------------------------------------------------------
	AST_READ_WAIT: assert property (taken && !hwrite |=> readWait)
		else $error("read answer not after exactly one wait");
	AST_WRITE_NOWAIT: assert property (taken && hwrite |=> hreadyout)
		else $error("write data phase stalled");
	AST_HRDATA_HOLD: assert property (hreadyout |=> $stable(hrdata))
		else $error("read data moved outside a read");
	AST_RESP_OKAY: assert property (hresp == 1'b0)
		else $error("response not okay");
	AST_RESET_QUIET: assert property ($fell(sys_rst) |-> quietOut)
		else $error("outputs not cleared by reset");
	AST_BRAKE_MOE: assert property (brakeActive |=> !mainOutputEnable)
		else $error("brake left output enable set");
	AST_BRAKE_STICKY: assert property (irqRequest[7] && !wrPhase |=> irqRequest[7])
		else $error("brake request dropped without a write");
	AST_UPDATE_STICKY: assert property (irqRequest[0] && !wrPhase |=> irqRequest[0])
		else $error("update request dropped without a write");
endmodule

bind tef_flags tef_flags_checker tef_flags_checker_inst (
	.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .brakeActive(brakeActive), .mainOutputEnable(mainOutputEnable),
	.irqRequest(irqRequest), .dmaRequest(dmaRequest)
);

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	import tef_pkg::*;
	logic        clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rdPend = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [7:0]  ev = 8'h00;
	logic [15:0] en, cnt;
	logic        hreadyout, hresp, mainOutputEnable;
	logic [31:0] hrdata, expQ [$];
	logic [15:0] channelConfig, mainCounter;
	logic [7:0]  irqRequest;
	logic [6:0]  dmaRequest;
	int          seed = 32'h3b0b6c44, numErrors = 0, checksDone = 0;
	logic [15:0] ctrlTab [3] = '{16'h0000, 16'h0002, 16'h0004};
	logic [15:0] runTab [4] = '{16'h0001, 16'h0021, 16'h0001, 16'h0003};
	logic [15:0] expTab [4] = '{16'h0002, 16'h0000, 16'h0001, 16'h0000};

	always #50 clk = ~clk;

	// ev packs the event inputs: [3:0] capture, trigger active, any edge, commutation, brake
	tef_flags tef_flags_inst (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.captureEvent(ev[3:0]), .triggerActiveEdge(ev[4]), .triggerAnyEdge(ev[5]),
		.gateLevel(1'b0), .brakeActive(ev[7]), .commutationEvent(ev[6]),
		.mainCounter(mainCounter), .mainOutputEnable(mainOutputEnable),
		.channelConfig(channelConfig), .irqRequest(irqRequest), .dmaRequest(dmaRequest));

	// ------------------------------------------------------------
	// bus master and checking tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp)
		begin
			numErrors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// ready is judged mid-cycle, where it has settled, and acted on at the next edge
	task automatic waitRdy();
		logic r;
		do
		begin
			@(negedge clk);
			r = hreadyout;
			@(posedge clk);
		end
		while (r !== 1'b1);
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
		hsel <= 1'b1;
		htrans <= TEF_HTRANS_NSEQ;
		hwrite <= w;
		haddr <= {24'h0, a};
		waitRdy();
		htrans <= 2'h0;
		hwdata <= {16'h0, d};
		waitRdy();
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		expQ.push_back({16'h0, e});
		xfer(1'b0, a, 16'h0);
	endtask
	task automatic pulse(input logic [7:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= 8'h00;
		@(posedge clk);
	endtask
	task automatic stopTest();
		$display("errors %0d checks %0d", numErrors, checksDone);
		if (numErrors == 0 && checksDone > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// read data is taken from the queue once the answer shows ready
	always @(negedge clk)
	begin
		if (rdPend && hreadyout === 1'b1)
		begin
			chk("hrdata", hrdata, expQ.pop_front());
			rdPend = 1'b0;
		end
		if (hsel && !hwrite && htrans == TEF_HTRANS_NSEQ && hreadyout === 1'b1)
			rdPend = 1'b1;
	end

	// generous bound: the sequence needs a few hundred cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		numErrors++;
		stopTest();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		rd(TEF_OFF_FLAGS, 16'h0);
		rd(TEF_OFF_EVGEN, 16'h0);
		rd(8'h80, 16'h0);
		for (int i = 0; i < 3; i++)
		begin
			wr(TEF_OFF_CTRL, ctrlTab[i]);
			wr(TEF_OFF_COUNT, 16'h0077);
			wr(TEF_OFF_EVGEN, 16'h0001);
			rd(TEF_OFF_COUNT, 16'h0);
			rd(TEF_OFF_FLAGS, {15'h0, i == 0});
			rd(TEF_OFF_EVGEN, 16'h0);
			wr(TEF_OFF_FLAGS, 16'h0);
		end
		wr(TEF_OFF_CTRL, 16'h0010);
		wr(TEF_OFF_RELOAD, 16'h0abc);
		wr(TEF_OFF_EVGEN, 16'h0001);
		rd(TEF_OFF_COUNT, 16'h0abc);
		chk("cnt", {16'h0, mainCounter}, 32'h0abc);
		wr(TEF_OFF_FLAGS, 16'h1eff);
		rd(TEF_OFF_FLAGS, 16'h0001);
		wr(TEF_OFF_CTRL, 16'h0);
		wr(TEF_OFF_FLAGS, 16'h0);
		wr(TEF_OFF_EVGEN, 16'h0);
		rd(TEF_OFF_FLAGS, 16'h0);
		wr(TEF_OFF_EVGEN, 16'h0040);
		rd(TEF_OFF_FLAGS, 16'h0040);
		wr(TEF_OFF_MODE, 16'h0002);
		// the enable lands at this very edge, so look once it has settled
		@(negedge clk);
		chk("moe", {31'h0, mainOutputEnable}, 32'h1);
		@(posedge clk);
		wr(TEF_OFF_CFGPRE, 16'h0a5c);
		wr(TEF_OFF_EVGEN, 16'h00a0);
		rd(TEF_OFF_FLAGS, 16'h00c0);
		chk("moe", {31'h0, mainOutputEnable}, 32'h0);
		chk("cfg", {16'h0, channelConfig}, 32'h0);
		wr(TEF_OFF_MODE, 16'h0001);
		wr(TEF_OFF_FLAGS, 16'h0);
		wr(TEF_OFF_EVGEN, 16'h0020);
		rd(TEF_OFF_FLAGS, 16'h0020);
		chk("cfg", {16'h0, channelConfig}, 32'h0a5c);
		rd(TEF_OFF_CFGACT, 16'h0a5c);
		wr(TEF_OFF_FLAGS, 16'h0);
		wr(TEF_OFF_CFGPRE, 16'h0c3a);
		pulse(8'h40);
		rd(TEF_OFF_FLAGS, 16'h0020);
		chk("cfg", {16'h0, channelConfig}, 32'h0c3a);
		// gated mode counts any edge, other modes need the active edge
		for (int g = 1; g >= 0; g--)
		begin
			wr(TEF_OFF_MODE, g ? 16'h0004 : 16'h0000);
			wr(TEF_OFF_FLAGS, 16'h0);
			pulse(8'h20);
			rd(TEF_OFF_FLAGS, g ? 16'h0040 : 16'h0000);
		end
		pulse(8'h10);
		rd(TEF_OFF_FLAGS, 16'h0040);
		wr(TEF_OFF_FLAGS, 16'h0);
		wr(TEF_OFF_EVGEN, 16'h0001);
		pulse(8'h80);
		rd(TEF_OFF_FLAGS, 16'h0081);
		for (int i = 0; i < 6; i++)
		begin
			en = 16'($random(seed)) & TEF_ENABLE_MASK;
			wr(TEF_OFF_ENABLE, en);
			@(negedge clk);
			chk("irq", {24'h0, irqRequest}, {24'h0, en[7:0] & 8'h81});
			chk("dma", {25'h0, dmaRequest}, {25'h0, en[14:8] & 7'h01});
			@(posedge clk);
		end
		wr(TEF_OFF_ENABLE, 16'h0);
		wr(TEF_OFF_CHDIR, 16'h000f);
		wr(TEF_OFF_FLAGS, 16'h0);
		for (int c = 0; c < 4; c++)
		begin
			cnt = 16'($random(seed));
			wr(TEF_OFF_COUNT, cnt);
			pulse({4'h0, 4'h1 << c});
			pulse({4'h0, 4'h1 << c});
			rd(TEF_OFF_FLAGS, 16'h0202 << c);
			rd(TEF_OFF_CCR1 + 8'(4 * c), cnt);
			rd(TEF_OFF_FLAGS, 16'h0200 << c);
			wr(TEF_OFF_FLAGS, 16'h0);
			wr(TEF_OFF_EVGEN, 16'h0002 << c);
			rd(TEF_OFF_FLAGS, 16'h0002 << c);
			wr(TEF_OFF_EVGEN, 16'h0002 << c);
			rd(TEF_OFF_FLAGS, 16'h0202 << c);
			wr(TEF_OFF_FLAGS, 16'h0200 << c);
			rd(TEF_OFF_FLAGS, 16'h0200 << c);
			wr(TEF_OFF_FLAGS, 16'h0);
		end
		wr(TEF_OFF_CHDIR, 16'h0);
		wr(TEF_OFF_EVGEN, 16'h001e);
		rd(TEF_OFF_FLAGS, 16'h001e);
		wr(TEF_OFF_FLAGS, 16'h0);
		wr(TEF_OFF_CCR1, 16'h0005);
		wr(TEF_OFF_CHDIR, 16'h000e);
		// edge match, centred run, wrap with and without update disable
		for (int m = 0; m < 4; m++)
		begin
			wr(TEF_OFF_RELOAD, m < 2 ? 16'h00ff : 16'h0003);
			wr(TEF_OFF_COUNT, 16'h0);
			wr(TEF_OFF_CTRL, runTab[m]);
			repeat (12) @(posedge clk);
			wr(TEF_OFF_CTRL, 16'h0);
			rd(TEF_OFF_FLAGS, expTab[m]);
			wr(TEF_OFF_FLAGS, 16'h0);
		end
		// slave reset mode: the active trigger edge reinitialises, urs masks the update
		wr(TEF_OFF_MODE, 16'h0008);
		for (int u = 0; u < 2; u++)
		begin
			wr(TEF_OFF_CTRL, u ? 16'h0004 : 16'h0000);
			wr(TEF_OFF_COUNT, 16'h0055);
			wr(TEF_OFF_FLAGS, 16'h0);
			pulse(8'h10);
			rd(TEF_OFF_COUNT, 16'h0);
			rd(TEF_OFF_FLAGS, u ? 16'h0040 : 16'h0041);
		end
		// a reset in mid-run must drop the output enable, requests and counter
		wr(TEF_OFF_CTRL, 16'h0);
		wr(TEF_OFF_MODE, 16'h0002);
		wr(TEF_OFF_ENABLE, 16'h0040);
		wr(TEF_OFF_COUNT, 16'h0033);
		sys_rst <= 1'b1;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		chk("rst", {7'h0, mainOutputEnable, irqRequest, mainCounter}, 32'h0);
		@(posedge clk);
		rd(TEF_OFF_RELOAD, 16'hffff);
		rd(TEF_OFF_FLAGS, 16'h0);
		stopTest();
	end
endmodule
